// >>> hw/tpc_pkg.sv
// tpc_pkg: object indices, field positions and reset values of the touch-probe capture block
package tpc_pkg;

  // object indices of the process-data objects
  localparam logic [15:0] TPC_IDX_FUNC     = 16'h60B8;
  localparam logic [15:0] TPC_IDX_STATUS   = 16'h60B9;
  localparam logic [15:0] TPC_IDX_P1_RISE  = 16'h60BA;
  localparam logic [15:0] TPC_IDX_P1_FALL  = 16'h60BB;
  localparam logic [15:0] TPC_IDX_P2_RISE  = 16'h60BC;
  localparam logic [15:0] TPC_IDX_P2_FALL  = 16'h60BD;

  localparam int          TPC_WORD_W       = 16;
  localparam int          TPC_OBJ_W        = 32;
  localparam int          TPC_NUM_CH       = 2;
  localparam logic [15:0] TPC_FUNC_RESET   = 16'h0033;

  // each channel owns one byte of the function and status words
  localparam int          TPC_CH_STRIDE    = 8;

  // function word bits within a channel byte
  localparam int          TPC_FN_ENABLE    = 0;
  localparam int          TPC_FN_CONT      = 1;
  localparam int          TPC_FN_INDEX_SRC = 2;
  localparam int          TPC_FN_RISE_EN   = 4;
  localparam int          TPC_FN_FALL_EN   = 5;

  // status word bits within a channel byte
  localparam int          TPC_ST_ENABLED   = 0;
  localparam int          TPC_ST_RISE_HELD = 1;
  localparam int          TPC_ST_FALL_HELD = 2;
  localparam int          TPC_ST_RISE_TGL  = 6;
  localparam int          TPC_ST_FALL_TGL  = 7;

  // edge slots inside a channel
  localparam int          TPC_EDGE_RISE    = 0;
  localparam int          TPC_EDGE_FALL    = 1;

  typedef enum logic [2:0] {
    TPC_OBJ_FUNC,
    TPC_OBJ_STATUS,
    TPC_OBJ_P1_RISE,
    TPC_OBJ_P1_FALL,
    TPC_OBJ_P2_RISE,
    TPC_OBJ_P2_FALL,
    TPC_OBJ_NONE
  } tpc_obj_t;

endpackage : tpc_pkg

// >>> hw/tpc_chan_if.sv
// tpc_chan_if: control and capture results between the top and one probe channel
`timescale 1ns/100ps
interface tpc_chan_if #(
  parameter int W = 32
);
  logic         enable;
  logic         cont;
  logic         rise_en;
  logic         fall_en;
  logic         rise_evt;
  logic         fall_evt;
  logic [W-1:0] position;
  logic [W-1:0] rise_pos;
  logic [W-1:0] fall_pos;
  logic         rise_held;
  logic         fall_held;
  logic         rise_tgl;
  logic         fall_tgl;

  modport ctl (
    output enable, cont, rise_en, fall_en, rise_evt, fall_evt, position,
    input  rise_pos, fall_pos, rise_held, fall_held, rise_tgl, fall_tgl
  );

  modport cap (
    input  enable, cont, rise_en, fall_en, rise_evt, fall_evt, position,
    output rise_pos, fall_pos, rise_held, fall_held, rise_tgl, fall_tgl
  );
endinterface : tpc_chan_if

// >>> hw/tpc_channel.sv
// tpc_channel: per-channel edge capture, held flags, update toggles and single-shot arming
`timescale 1ns/100ps
module tpc_channel
  import tpc_pkg::*;
#(
  parameter int W = 32
)(
  input  wire logic  core_clk,  // control clock
  input  wire logic  sys_rst,   // sync reset, high
  tpc_chan_if.cap    ch         // channel control and results
);

  logic [1:0]   edge_en;
  logic [1:0]   edge_evt;
  logic [1:0]   take;
  logic [1:0]   shot_done_reg;
  logic [1:0]   held_reg;
  logic [1:0]   tgl_reg;
  logic [W-1:0] val_reg [2];

  if (W < 1)
  begin : g_bad_w
    $error("tpc_channel: W must be at least 1");
  end

  assign edge_en[TPC_EDGE_RISE]  = ch.rise_en;
  assign edge_en[TPC_EDGE_FALL]  = ch.fall_en;
  assign edge_evt[TPC_EDGE_RISE] = ch.rise_evt;
  assign edge_evt[TPC_EDGE_FALL] = ch.fall_evt;

  genvar e;
  generate
    for (e = 0; e < 2; e++)
    begin : g_edge
      // a disabled channel or edge never captures; single mode fires once per arming
      assign take[e] = ch.enable & edge_en[e] & edge_evt[e] & (ch.cont | ~shot_done_reg[e]);

      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
          shot_done_reg[e] <= 1'b0;
        else if (!edge_en[e])
          shot_done_reg[e] <= 1'b0;
        else if (take[e] && !ch.cont)
          shot_done_reg[e] <= 1'b1;
      end

      // capture wins over the clear; both cannot coincide since take needs the edge enable
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
          held_reg[e] <= 1'b0;
        else if (take[e])
          held_reg[e] <= 1'b1;
        else if (!edge_en[e])
          held_reg[e] <= 1'b0;
      end

      // toggle survives re-arming so the master never misses a flip
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
          tgl_reg[e] <= 1'b0;
        else if (take[e])
          tgl_reg[e] <= ~tgl_reg[e];
      end

      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
          val_reg[e] <= '0;
        else if (take[e])
          val_reg[e] <= ch.position;
      end
    end
  endgenerate

  assign ch.rise_pos  = val_reg[TPC_EDGE_RISE];
  assign ch.fall_pos  = val_reg[TPC_EDGE_FALL];
  assign ch.rise_held = held_reg[TPC_EDGE_RISE];
  assign ch.fall_held = held_reg[TPC_EDGE_FALL];
  assign ch.rise_tgl  = tgl_reg[TPC_EDGE_RISE];
  assign ch.fall_tgl  = tgl_reg[TPC_EDGE_FALL];

endmodule : tpc_channel

// >>> hw/tpc_top.sv
// tpc_top: two-channel touch-probe position capture with function/status words and object access
`timescale 1ns/100ps

// How it works
// - function bit 0 turns probe channel 1 on; off means no capture.
// - function bit 1 picks single (0) or continuous (1) triggering for channel 1.
// - function bit 2 picks probe 1 input (0) or encoder index (1) as source.
// - function bit 4 latches position on each rising edge of channel 1 source.
// - function bit 5 latches position on each falling edge of channel 1 source.
// - channel 2 uses bits 8, 9, 10, 12, 13 the same way.
// - 16-bit function word is writable and resets to 0x0033.
// - status bit 0 and bit 8 show channel 1 and 2 enabled.
// - status bits 1 and 2 show channel 1 rising and falling value stored.
// - status bits 9 and 10 show channel 2 rising and falling value stored.
// - status bits 6 and 7 flip on each channel 1 rising and falling update.
// - status bits 14 and 15 flip on each channel 2 rising and falling update.
// - continuous mode flips the toggle on every capture; master compares toggles.
// - clearing edge enables 4, 5, 12, 13 clears the matching stored flags.
// - channel 1 rising capture is a read-only signed 32-bit user-unit value.
// - channel 1 falling capture sits in its own read-only value.
// - channel 2 rising and falling captures sit in two read-only values.
module tpc_top
  import tpc_pkg::*;
#(
  parameter int POS_W = 32
)(
  input  wire logic                 core_clk,                // control clock, 40 MHz
  input  wire logic                 sys_rst,                 // sync reset, high
  input  wire logic [1:0]           probe_in,                // touch-probe inputs, bit n is probe n+1
  input  wire logic                 index_pulse,             // encoder index pulse
  input  wire logic [POS_W-1:0]     user_position_unit,      // actual position, signed user units
  input  wire logic                 obj_wr,                  // object write strobe
  input  wire logic                 obj_rd,                  // object read strobe
  input  wire logic [15:0]          obj_idx,                 // object index
  input  wire logic [TPC_OBJ_W-1:0] obj_wdata,               // write data, low 16 bits used
  output logic      [TPC_OBJ_W-1:0] obj_rdata,               // read data
  output logic                      obj_ack,                 // access done, one cycle
  output logic                      obj_err,                 // access refused, with ack
  output logic      [15:0]          probe_function_control,  // function word, mapped
  output logic      [15:0]          probe_capture_status,    // status word, mapped
  output logic      [POS_W-1:0]     probe1_rising_position,  // channel 1 rising capture
  output logic      [POS_W-1:0]     probe1_falling_position, // channel 1 falling capture
  output logic      [POS_W-1:0]     probe2_rising_position,  // channel 2 rising capture
  output logic      [POS_W-1:0]     probe2_falling_position  // channel 2 falling capture
);
  import tpc_pkg::*;

  if (POS_W < 1 || POS_W > TPC_OBJ_W)
  begin : g_bad_pos_w
    $error("tpc_top: POS_W must lie in 1..32");
  end

  function automatic tpc_obj_t obj_decode(input logic [15:0] idx);
    case (idx)
      TPC_IDX_FUNC:    obj_decode = TPC_OBJ_FUNC;
      TPC_IDX_STATUS:  obj_decode = TPC_OBJ_STATUS;
      TPC_IDX_P1_RISE: obj_decode = TPC_OBJ_P1_RISE;
      TPC_IDX_P1_FALL: obj_decode = TPC_OBJ_P1_FALL;
      TPC_IDX_P2_RISE: obj_decode = TPC_OBJ_P2_RISE;
      TPC_IDX_P2_FALL: obj_decode = TPC_OBJ_P2_FALL;
      default:         obj_decode = TPC_OBJ_NONE;
    endcase
  endfunction : obj_decode

  // widen a capture to the object width with sign extension
  function automatic logic [TPC_OBJ_W-1:0] sext(input logic [POS_W-1:0] v);
    logic [TPC_OBJ_W-1:0] r;
    r = {TPC_OBJ_W{v[POS_W-1]}};
    r[POS_W-1:0] = v;
    sext = r;
  endfunction : sext

  logic [15:0]          func_reg;
  logic [15:0]          status_word;
  logic [1:0]           probe_prev_reg;
  logic                 index_prev_reg;
  logic [1:0]           src_prev_reg;
  logic                 wr_hit;
  tpc_obj_t             rd_obj;
  tpc_obj_t             wr_obj;
  logic [TPC_OBJ_W-1:0] rdata_next;
  logic [TPC_OBJ_W-1:0] rdata_reg;
  logic                 ack_reg;
  logic                 err_reg;
  logic [POS_W-1:0]     rise_pos_w [TPC_NUM_CH];
  logic [POS_W-1:0]     fall_pos_w [TPC_NUM_CH];

  assign rd_obj = obj_decode(obj_idx);
  assign wr_obj = obj_decode(obj_idx);
  // only the function word accepts writes; a write clashing with a read is refused
  assign wr_hit = obj_wr && !obj_rd && (wr_obj == TPC_OBJ_FUNC);

  // all 16 bits are stored and read back; reserved ones steer nothing
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      func_reg <= TPC_FUNC_RESET;
    else if (wr_hit)
      func_reg <= obj_wdata[15:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      probe_prev_reg <= 2'h0;
      index_prev_reg <= 1'b0;
    end
    else
    begin
      probe_prev_reg <= probe_in;
      index_prev_reg <= index_pulse;
    end
  end

  // remember which source each channel used, so a source switch is not an edge
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      src_prev_reg <= 2'h0;
    else
    begin
      src_prev_reg[0] <= func_reg[TPC_FN_INDEX_SRC];
      src_prev_reg[1] <= func_reg[TPC_CH_STRIDE + TPC_FN_INDEX_SRC];
    end
  end

  genvar c;
  generate
    for (c = 0; c < TPC_NUM_CH; c++)
    begin : g_ch
      localparam int B = c * TPC_CH_STRIDE;
      logic src_sel;
      logic cur_lvl;
      logic old_lvl;
      logic src_stable;

      tpc_chan_if #(.W(POS_W)) chan ();

      assign src_sel    = func_reg[B + TPC_FN_INDEX_SRC];
      assign cur_lvl    = src_sel ? index_pulse : probe_in[c];
      assign old_lvl    = src_sel ? index_prev_reg : probe_prev_reg[c];
      assign src_stable = (src_prev_reg[c] == src_sel);

      assign chan.enable   = func_reg[B + TPC_FN_ENABLE];
      assign chan.cont     = func_reg[B + TPC_FN_CONT];
      assign chan.rise_en  = func_reg[B + TPC_FN_RISE_EN];
      assign chan.fall_en  = func_reg[B + TPC_FN_FALL_EN];
      assign chan.rise_evt = src_stable & cur_lvl & ~old_lvl;
      assign chan.fall_evt = src_stable & ~cur_lvl & old_lvl;
      assign chan.position = user_position_unit;

      tpc_channel #(.W(POS_W)) u_channel (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ch       (chan.cap)
      );

      assign rise_pos_w[c] = chan.rise_pos;
      assign fall_pos_w[c] = chan.fall_pos;

      // status byte of this channel; unlisted bits stay zero
      assign status_word[B + TPC_ST_ENABLED]   = func_reg[B + TPC_FN_ENABLE];
      assign status_word[B + TPC_ST_RISE_HELD] = chan.rise_held;
      assign status_word[B + TPC_ST_FALL_HELD] = chan.fall_held;
      assign status_word[B + 5:B + 3]          = 3'h0;
      assign status_word[B + TPC_ST_RISE_TGL]  = chan.rise_tgl;
      assign status_word[B + TPC_ST_FALL_TGL]  = chan.fall_tgl;
    end
  endgenerate

  always_comb
  begin
    rdata_next = '0;
    case (rd_obj)
      TPC_OBJ_FUNC:    rdata_next = {16'h0000, func_reg};
      TPC_OBJ_STATUS:  rdata_next = {16'h0000, status_word};
      TPC_OBJ_P1_RISE: rdata_next = sext(rise_pos_w[0]);
      TPC_OBJ_P1_FALL: rdata_next = sext(fall_pos_w[0]);
      TPC_OBJ_P2_RISE: rdata_next = sext(rise_pos_w[1]);
      TPC_OBJ_P2_FALL: rdata_next = sext(fall_pos_w[1]);
      default:         rdata_next = '0;
    endcase
  end

  // answer one cycle after the strobe; unmapped or read-only writes are refused
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= '0;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end
    else
    begin
      ack_reg <= obj_rd | obj_wr;
      if (obj_rd && obj_wr)
        err_reg <= 1'b1;
      else if (obj_rd)
        err_reg <= (rd_obj == TPC_OBJ_NONE);
      else if (obj_wr)
        err_reg <= !wr_hit;
      else
        err_reg <= 1'b0;
      if (obj_rd && !obj_wr)
        rdata_reg <= rdata_next;
    end
  end

  assign obj_rdata               = rdata_reg;
  assign obj_ack                 = ack_reg;
  assign obj_err                 = err_reg;
  assign probe_function_control  = func_reg;
  assign probe_capture_status    = status_word;
  assign probe1_rising_position  = rise_pos_w[0];
  assign probe1_falling_position = fall_pos_w[0];
  assign probe2_rising_position  = rise_pos_w[1];
  assign probe2_falling_position = fall_pos_w[1];

endmodule : tpc_top

// >>> tb/tpc_sva.sv
// tpc_sva: port-level checks of tpc_top
`timescale 1ns/100ps
module tpc_sva #(
  parameter int POS_W = 32
)(
  input wire logic             core_clk,               // clock
  input wire logic             sys_rst,                // reset
  input wire logic [1:0]       probe_in,               // probes
  input wire logic             index_pulse,            // index
  input wire logic [POS_W-1:0] user_position_unit,     // position
  input wire logic             obj_wr,                 // write
  input wire logic             obj_rd,                 // read
  input wire logic [15:0]      obj_idx,                // object
  input wire logic [31:0]      obj_wdata,              // wdata
  input wire logic             obj_ack,                // ack
  input wire logic             obj_err,                // refused
  input wire logic [15:0]      probe_function_control, // function
  input wire logic [15:0]      probe_capture_status,   // status
  input wire logic [POS_W-1:0] probe1_rising_position, // p1 rise
  input wire logic [POS_W-1:0] probe2_falling_position // p2 fall
);
  wire logic [15:0] fc = probe_function_control;
  wire logic [15:0] st = probe_capture_status;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  ack_timing_a: assert property ((obj_rd || obj_wr) |=> obj_ack)
    else $error("strobe without ack");
  func_write_a: assert property (obj_wr && !obj_rd && obj_idx == 16'h60B8 |=> !obj_err && fc == 16'($past(obj_wdata)))
    else $error("function write lost");
  ro_write_a: assert property (obj_wr && obj_idx != 16'h60B8 |=> obj_err && $stable(fc))
    else $error("read-only write accepted");
  en_mirror_a: assert property (st[0] == fc[0] && st[8] == fc[8])
    else $error("enabled bits wrong");
  rsvd_zero_a: assert property ((st & 16'h3838) == 16'h0000)
    else $error("reserved status bit set");
  off_quiet_a: assert property (!fc[0] |=> $stable(probe1_rising_position) && $stable(st[7:6]))
    else $error("capture while off");
  held_clear_a: assert property (!fc[4] |=> !st[1])
    else $error("held flag not cleared");
  rise_cap_a: assert property ($rose(probe_in[0]) && !$past(sys_rst) && $stable(fc)
    && fc[0] && fc[1] && !fc[2] && fc[4]
    |=> st[1] && probe1_rising_position == $past(user_position_unit) && st[6] != $past(st[6]))
    else $error("rising capture wrong");
  fall_cap_a: assert property ($fell(index_pulse) && !$past(sys_rst) && $stable(fc)
    && fc[8] && fc[9] && fc[10] && fc[13]
    |=> st[10] && probe2_falling_position == $past(user_position_unit) && st[15] != $past(st[15]))
    else $error("falling capture wrong");
endmodule : tpc_sva

// >>> tb/tpc_master_model.sv
// tpc_master_model: fieldbus master doing object accesses
`timescale 1ns/100ps
module tpc_master_model (
  input  wire logic        core_clk,  // clock
  output logic             obj_wr,    // write
  output logic             obj_rd,    // read
  output logic [15:0]      obj_idx,   // object
  output logic [31:0]      obj_wdata, // wdata
  input  wire logic [31:0] obj_rdata, // rdata
  input  wire logic        obj_ack,   // ack
  input  wire logic        obj_err    // refused
);
  initial
  begin
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    obj_idx = 16'h0000;
    obj_wdata = 32'h0;
  end
  // strobe is a one-cycle pulse, answer taken before release
  task automatic access(input logic w, input logic [15:0] ix, input logic [31:0] wd,
                        output logic [31:0] d, output logic e, output logic ok);
    @(negedge core_clk);
    obj_wr = w;
    obj_rd = !w;
    obj_idx = ix;
    obj_wdata = wd;
    @(negedge core_clk);
    ok = obj_ack;
    d = obj_rdata;
    e = obj_err;
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    // released lines inverted so stale values cannot pass
    obj_idx = ~ix;
    obj_wdata = ~wd;
  endtask : access
endmodule : tpc_master_model

// >>> tb/tpc_top_tb_top.sv
// tpc_top_tb_top: random and corner-case bench for tpc_top
`timescale 1ns/100ps
module tpc_top_tb_top
  import tpc_pkg::*;
();
  logic        core_clk, sys_rst, index_pulse, obj_wr, obj_rd, obj_ack, obj_err;
  logic [1:0]  probe_in;
  logic [15:0] obj_idx, fcw, stw, f;
  logic [31:0] user_position_unit, obj_wdata, obj_rdata;
  logic [31:0] pos [4];
  logic [31:0] ep [4];
  logic [3:0]  h, t, fired;
  int          n_errors, total_checks, i;
  logic [15:0] fseq [8] = '{16'h0033, 16'h3531, 16'h0531, 16'h3531, 16'h3F17, 16'h3300, 16'hFFFF, 16'h0032};

  tpc_top u_tpc_top (.core_clk, .sys_rst, .probe_in, .index_pulse, .user_position_unit, .obj_wr, .obj_rd,
    .obj_idx, .obj_wdata, .obj_rdata, .obj_ack, .obj_err, .probe_function_control(fcw),
    .probe_capture_status(stw), .probe1_rising_position(pos[0]), .probe1_falling_position(pos[1]),
    .probe2_rising_position(pos[2]), .probe2_falling_position(pos[3]));
  tpc_master_model u_tpc_master_model (.core_clk, .obj_wr, .obj_rd, .obj_idx, .obj_wdata, .obj_rdata,
    .obj_ack, .obj_err);

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] st_exp(logic [15:0] v, logic [3:0] hv, logic [3:0] tv);
    st_exp = {tv[3:2], 3'b000, hv[3:2], v[8], tv[1:0], 3'b000, hv[1:0], v[0]};
  endfunction : st_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic print_verdict;
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic acc(input logic w, input logic [15:0] ix, input logic [31:0] wd, input logic ee, input logic [31:0] x);
    logic [31:0] d;
    logic e, ok;
    u_tpc_master_model.access(w, ix, wd, d, e, ok);
    chk({30'h0, ok, e}, {30'h0, 1'b1, ee});
    if (!w && !ee)
      chk(d, x);
  endtask : acc

  task automatic wr(input logic [15:0] v);
    int k;
    acc(1'b1, TPC_IDX_FUNC, {16'h0000, v}, 1'b0, 32'h0);
    chk({16'h0, fcw}, {16'h0, v});
    f = v;
    for (k = 0; k < 4; k++)
      if (!f[8 * (k / 2) + 4 + k % 2])
      begin
        h[k] = 1'b0;
        fired[k] = 1'b0;
      end
    // let a source switch settle before the next edge
    repeat (3) @(negedge core_clk);
  endtask : wr

  task automatic step(input logic [1:0] p, input logic ix);
    logic [1:0] src, old;
    int c, e;
    @(negedge core_clk);
    old = {f[10] ? index_pulse : probe_in[1], f[2] ? index_pulse : probe_in[0]};
    probe_in = p;
    index_pulse = ix;
    user_position_unit = $urandom;
    src = {f[10] ? ix : p[1], f[2] ? ix : p[0]};
    for (c = 0; c < 2; c++)
      for (e = 0; e < 2; e++)
        if (f[8*c] && f[8*c+4+e] && (f[8*c+1] || !fired[2*c+e]) && src[c] != old[c] && src[c] == (e == 0))
        begin
          h[2*c+e] = 1'b1;
          t[2*c+e] ^= 1'b1;
          // only a single-mode capture uses up the shot
          fired[2*c+e] |= !f[8*c+1];
          ep[2*c+e] = user_position_unit;
        end
    repeat (2) @(negedge core_clk);
    chk({16'h0, stw}, {16'h0, st_exp(f, h, t)});
    for (c = 0; c < 4; c++)
      chk(pos[c], ep[c]);
  endtask : step

  initial
  begin
    i = $urandom(95780);
    sys_rst = 1'b1;
    probe_in = 2'b00;
    index_pulse = 1'b0;
    user_position_unit = 32'h0;
    n_errors = 0;
    total_checks = 0;
    f = TPC_FUNC_RESET;
    h = 4'h0;
    t = 4'h0;
    fired = 4'h0;
    ep = '{default: 32'h0};
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    acc(1'b0, TPC_IDX_FUNC, 32'h0, 1'b0, 32'h0033);
    acc(1'b0, TPC_IDX_STATUS, 32'h0, 1'b0, 32'h0001);
    for (i = 1; i < 7; i++)
      acc(1'b1, TPC_IDX_FUNC + 16'(i), $urandom, 1'b1, 32'h0);
    acc(1'b0, 16'h60BE, 32'h0, 1'b1, 32'h0);
    acc(1'b0, TPC_IDX_FUNC, 32'h0, 1'b0, 32'h0033);
    for (i = 0; i < 8; i++)
    begin
      wr(fseq[i]);
      step(~probe_in, ~index_pulse);
      repeat (12) step(2'($urandom), 1'($urandom));
    end
    acc(1'b0, TPC_IDX_STATUS, 32'h0, 1'b0, {16'h0, st_exp(f, h, t)});
    for (i = 0; i < 4; i++)
      acc(1'b0, TPC_IDX_P1_RISE + 16'(i), 32'h0, 1'b0, ep[i]);
    print_verdict();
  end
endmodule : tpc_top_tb_top

bind tpc_top tpc_sva #(.POS_W(POS_W)) u_tpc_sva (.core_clk, .sys_rst, .probe_in, .index_pulse,
  .user_position_unit, .obj_wr, .obj_rd, .obj_idx, .obj_wdata, .obj_ack, .obj_err, .probe_function_control,
  .probe_capture_status, .probe1_rising_position, .probe2_falling_position);
